// ### rtl/phbu_consts.svh
`ifndef PHBU_CONSTS_SVH
`define PHBU_CONSTS_SVH

// Register byte offsets
`define PHBU_OFS_CTRL       8'h00
`define PHBU_OFS_STATUS     8'h04
`define PHBU_OFS_SEARCHES   8'h08
`define PHBU_OFS_WRITES     8'h0c
`define PHBU_OFS_LAST_PTE   8'h10

// Control field positions and reset values
`define PHBU_CTRL_HIST_EN   0
`define PHBU_CTRL_DC_EN     1
`define PHBU_CTRL_RST       32'h0000_0001

// History bit positions in the page table entry word
`define PHBU_PTE_R_BIT      8
`define PHBU_PTE_C_BIT      7

`endif

// ### rtl/phbu_pkg.sv
package phbu_pkg;

    // One translated access offered by the load/store and fetch units
    typedef struct packed {
        logic        is_instr;     // Fetch side, else data side
        logic        is_store;
        logic        is_touch;     // Cache block or stream touch
        logic        block_hit;    // Mapped by a block translation entry
        logic        direct_store; // Segment is direct-store
        logic        tlb_hit;
        logic        tlb_c;        // Cached changed copy
        logic        store_ok;     // Protection allows, on execution path
        logic [31:0] pte_addr;     // Physical address of the entry word
    } phbu_acc_t;

    // Attributes of the history update accesses
    typedef struct packed {
        logic xlate_off;
        logic write_thru;
        logic inhibit;
        logic coherent;
        logic guarded;
    } phbu_attr_t;

    // Cached translation entry reload
    typedef struct packed {
        logic [31:0] pte_addr;
        logic        r;
        logic        c;
    } phbu_tlb_load_t;

    typedef enum logic [1:0] {
        PHBU_EXT_NONE,
        PHBU_EXT_LINE_FILL,
        PHBU_EXT_SINGLE_READ,
        PHBU_EXT_SINGLE_WRITE
    } phbu_ext_op_t;

    typedef enum logic [1:0] {
        PHBU_IDLE,
        PHBU_READ,
        PHBU_WRITE,
        PHBU_RELOAD
    } phbu_state_t;

endpackage : phbu_pkg

// ### rtl/phbu_top.sv
`timescale 1ns/1ps
`include "phbu_consts.svh"

module phbu_top (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // Access offer
    input  wire logic                   acc_valid,
    input  wire phbu_pkg::phbu_acc_t    acc,
    input  wire logic                   instr_translate_enable,
    input  wire logic                   data_translate_enable,
    output logic                        acc_ready,
    output logic                        acc_done,
    // Page table memory port through the data cache
    output logic                        mem_req,
    output logic                        mem_we,
    output logic [31:0]                 mem_addr,
    output logic [31:0]                 mem_wdata,
    output phbu_pkg::phbu_attr_t        mem_attr,
    output phbu_pkg::phbu_ext_op_t      mem_ext_op,
    input  wire logic                   mem_ack,
    input  wire logic [31:0]            mem_rdata,
    input  wire logic                   dc_hit,
    // Cached translation entry reload
    output logic                        tlb_load,
    output phbu_pkg::phbu_tlb_load_t    tlb_load_data,
    // Avalon-MM register slave
    input  wire logic [7:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest
);

    phbu_pkg::phbu_state_t    state_r;
    phbu_pkg::phbu_state_t    state_nxt;
    phbu_pkg::phbu_acc_t      acc_r;
    phbu_pkg::phbu_ext_op_t   ext_op_r;
    phbu_pkg::phbu_tlb_load_t tlb_data_r;
    logic                     want_c_r;
    logic                     dc_hit_r;
    logic [31:0]              pte_word_r;
    logic [31:0]              addr_r;
    logic [31:0]              wdata_r;
    logic                     done_r;
    logic                     load_r;
    logic [31:0]              ctrl_r;
    logic [31:0]              searches_r;
    logic [31:0]              writes_r;
    logic [31:0]              last_pte_r;
    logic                     bus_ack_r;
    logic [31:0]              rdata_r;

    // Register bus decode, declared ahead of the counters that use it
    wire logic                reg_req;
    wire logic                reg_wr;
    wire logic                reg_rd;
    wire logic                sel_ctrl;
    wire logic                sel_status;
    wire logic                sel_searches;
    wire logic                sel_writes;
    wire logic                sel_last_pte;

    // Phase decode of the update sequencer
    wire logic                in_idle;
    wire logic                in_read;
    wire logic                in_write;
    wire logic                in_reload;
    wire logic                take_search;

    // Whether an offered access must launch a table search
    function automatic logic needs_search(
        input phbu_pkg::phbu_acc_t a,
        input logic                ien,
        input logic                den,
        input logic                hist_en
    );
        logic xlate;
        xlate = a.is_instr ? ien : den;
        needs_search = 1'b0;
        if (hist_en && xlate && !a.block_hit && !a.direct_store)
        begin
            if (!a.tlb_hit)
                needs_search = 1'b1;
            else if (a.is_store && !a.is_touch && a.store_ok
                     && !a.tlb_c)
                needs_search = 1'b1;
            // Hit with changed set, or a read hit: nothing
        end
    endfunction : needs_search

    // Changed bit wanted only for real, permitted stores
    function automatic logic wants_changed(
        input phbu_pkg::phbu_acc_t a
    );
        wants_changed = a.is_store && !a.is_touch && a.store_ok;
    endfunction : wants_changed

    // Register word select; offsets are byte addresses
    function automatic logic reg_at(
        input logic [7:0] a,
        input logic [7:0] ofs
    );
        reg_at = (a == ofs);
    endfunction : reg_at

    // Offer decode
    wire logic take_acc;
    wire logic search_go;
    assign take_acc  = acc_valid && acc_ready;
    assign search_go = needs_search(acc, instr_translate_enable,
                                    data_translate_enable,
                                    ctrl_r[`PHBU_CTRL_HIST_EN]);

    // Phase tests, shared by several processes
    assign in_idle     = (state_r == phbu_pkg::PHBU_IDLE);
    assign in_read     = (state_r == phbu_pkg::PHBU_READ);
    assign in_write    = (state_r == phbu_pkg::PHBU_WRITE);
    assign in_reload   = (state_r == phbu_pkg::PHBU_RELOAD);
    assign take_search = take_acc && search_go;

    // Merge: only ever set bits, keep every other field as read
    wire logic [31:0] set_mask;
    wire logic [31:0] merged_word;
    wire logic        word_changes;
    assign set_mask = (32'h0000_0001 << `PHBU_PTE_R_BIT)
                    | ({31'h0, want_c_r} << `PHBU_PTE_C_BIT);
    assign merged_word  = mem_rdata | set_mask;
    assign word_changes = (merged_word != mem_rdata);

    // Handshake outputs
    assign acc_ready = in_idle;
    assign mem_req   = in_read || in_write;
    assign mem_we    = in_write;

    // Update accesses: untranslated, cacheable, coherent, not guarded
    assign mem_attr.xlate_off  = 1'b1;
    assign mem_attr.write_thru = 1'b0;
    assign mem_attr.inhibit    = 1'b0;
    assign mem_attr.coherent   = 1'b1;
    assign mem_attr.guarded    = 1'b0;

    // Registered data outputs
    assign mem_addr      = addr_r;
    assign mem_wdata     = wdata_r;
    assign mem_ext_op    = ext_op_r;
    assign acc_done      = done_r;
    assign tlb_load      = load_r;
    assign tlb_load_data = tlb_data_r;

    // External transaction kind for the read of the entry word
    wire phbu_pkg::phbu_ext_op_t rd_op;
    wire phbu_pkg::phbu_ext_op_t wr_op;
    assign rd_op = dc_hit ? phbu_pkg::PHBU_EXT_NONE
                 : ctrl_r[`PHBU_CTRL_DC_EN]
                   ? phbu_pkg::PHBU_EXT_LINE_FILL
                   : phbu_pkg::PHBU_EXT_SINGLE_READ;
    // Line now resident when the cache is on, so the write stays inside
    assign wr_op = (dc_hit_r || ctrl_r[`PHBU_CTRL_DC_EN])
                 ? phbu_pkg::PHBU_EXT_NONE
                 : phbu_pkg::PHBU_EXT_SINGLE_WRITE;

    // Next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            phbu_pkg::PHBU_IDLE:
                if (take_acc && search_go)
                    state_nxt = phbu_pkg::PHBU_READ;
            phbu_pkg::PHBU_READ:
                if (mem_ack)
                    state_nxt = word_changes ? phbu_pkg::PHBU_WRITE
                                             : phbu_pkg::PHBU_RELOAD;
            phbu_pkg::PHBU_WRITE:
                if (mem_ack)
                    state_nxt = phbu_pkg::PHBU_RELOAD;
            phbu_pkg::PHBU_RELOAD:
                state_nxt = phbu_pkg::PHBU_IDLE;
            default:
                state_nxt = phbu_pkg::PHBU_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            state_r <= phbu_pkg::PHBU_IDLE;
        else
            state_r <= state_nxt;
    end

    // Capture the access and launch the entry read
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            acc_r    <= '0;
            want_c_r <= 1'b0;
            addr_r   <= 32'h0000_0000;
        end
        // Held for the whole search, so the caller may change its offer
        else if (take_search)
        begin
            acc_r    <= acc;
            want_c_r <= wants_changed(acc);
            addr_r   <= acc.pte_addr;
        end
    end

    // Transaction kind follows the cache answer of the read phase, held for the write
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ext_op_r <= phbu_pkg::PHBU_EXT_NONE;
            dc_hit_r <= 1'b0;
        end
        else if (in_read)
        begin
            ext_op_r <= rd_op;
            dc_hit_r <= dc_hit;
        end
        else if (in_write)
            ext_op_r <= wr_op;
        else
            ext_op_r <= phbu_pkg::PHBU_EXT_NONE;
    end

    // Entry word: read, merge, hold for write back
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pte_word_r <= 32'h0000_0000;
            wdata_r    <= 32'h0000_0000;
        end
        else if (in_read && mem_ack)
        begin
            pte_word_r <= merged_word;
            wdata_r    <= merged_word;
        end
    end

    // Reload of the cached entry and access completion
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            load_r     <= 1'b0;
            done_r     <= 1'b0;
            tlb_data_r <= '0;
        end
        else
        begin
            load_r <= in_reload;
            // Skipped accesses finish one cycle after they are taken
            done_r <= in_reload || (take_acc && !search_go);
            if (in_reload)
            begin
                tlb_data_r.pte_addr <= addr_r;
                tlb_data_r.r        <= 1'b1;
                // Reflects memory, so an earlier changed bit survives
                tlb_data_r.c <= pte_word_r[`PHBU_PTE_C_BIT];
            end
        end
    end

    // Activity counters and last written entry word
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            searches_r <= 32'h0000_0000;
            writes_r   <= 32'h0000_0000;
            last_pte_r <= 32'h0000_0000;
        end
        else
        begin
            // Hardware count wins over a software clear
            if (take_search)
                searches_r <= searches_r + 32'h0000_0001;
            else if (reg_wr && sel_searches)
                searches_r <= 32'h0000_0000;
            // Only answered write phases count
            if (in_write && mem_ack)
            begin
                writes_r   <= writes_r + 32'h0000_0001;
                last_pte_r <= wdata_r;
            end
            else if (reg_wr && sel_writes)
                writes_r <= 32'h0000_0000;
        end
    end

    // Avalon slave: one wait cycle per request, then the answer
    assign reg_req = (avs_read || avs_write) && !bus_ack_r;
    assign reg_wr  = avs_write && bus_ack_r;
    assign reg_rd  = avs_read && !bus_ack_r;
    assign avs_waitrequest = reg_req;
    assign avs_readdata    = rdata_r;

    // Word selects, shared by the read mux and the write decodes
    assign sel_ctrl     = reg_at(avs_address, `PHBU_OFS_CTRL);
    assign sel_status   = reg_at(avs_address, `PHBU_OFS_STATUS);
    assign sel_searches = reg_at(avs_address, `PHBU_OFS_SEARCHES);
    assign sel_writes   = reg_at(avs_address, `PHBU_OFS_WRITES);
    assign sel_last_pte = reg_at(avs_address, `PHBU_OFS_LAST_PTE);

    // Read mux; unmapped offsets read zero
    wire logic [31:0] status_word;
    wire logic [31:0] rd_mux;
    assign status_word = {29'h0, state_r != phbu_pkg::PHBU_IDLE,
                          state_r};
    assign rd_mux =
        sel_ctrl     ? ctrl_r      :
        sel_status   ? status_word :
        sel_searches ? searches_r  :
        sel_writes   ? writes_r    :
        sel_last_pte ? last_pte_r  :
        32'h0000_0000;

    // Bus handshake and read data
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            bus_ack_r <= 1'b0;
            rdata_r   <= 32'h0000_0000;
        end
        else
        begin
            bus_ack_r <= reg_req;
            if (reg_rd)
                rdata_r <= rd_mux;
        end
    end

    // Control register: history enable and data cache enable
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            ctrl_r <= `PHBU_CTRL_RST;
        else if (reg_wr && sel_ctrl && avs_byteenable[0])
            ctrl_r <= {30'h0, avs_writedata[1:0]};
    end

endmodule : phbu_top

// ### bench/phbu_top_asserts.sv
`timescale 1ns/1ps
`include "phbu_consts.svh"
module phbu_top_asserts (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     reset_n,
    // Access offer and completion
    input wire logic                     acc_valid,
    input wire phbu_pkg::phbu_acc_t      acc,
    input wire logic                     instr_translate_enable,
    input wire logic                     data_translate_enable,
    input wire logic                     acc_ready,
    input wire logic                     acc_done,
    // Memory port and entry reload
    input wire logic                     mem_req,
    input wire logic                     mem_we,
    input wire logic [31:0]              mem_addr,
    input wire logic [31:0]              mem_wdata,
    input wire phbu_pkg::phbu_attr_t     mem_attr,
    input wire logic                     mem_ack,
    input wire logic                     tlb_load,
    input wire phbu_pkg::phbu_tlb_load_t tlb_load_data
);
    // Accepted offer; paged means history is kept for it
    wire take     = acc_valid && acc_ready;
    wire xlate_on = acc.is_instr ? instr_translate_enable
                                 : data_translate_enable;
    wire paged    = take && xlate_on && !acc.block_hit && !acc.direct_store;
    wire quiet    = acc.tlb_c || !acc.is_store || !acc.store_ok
                    || acc.is_touch;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // A phase keeps address and direction until answered
    req_hold_a: assert property (mem_req && !mem_ack |=>
        mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory phase changed before answer");
    upd_attr_a: assert property (mem_req |-> mem_attr.xlate_off
        && mem_attr.coherent && !mem_attr.guarded && !mem_attr.inhibit)
        else $error("update access attributes wrong");
    ref_kept_a: assert property (mem_req && mem_we |->
        mem_wdata[`PHBU_PTE_R_BIT]) else $error("entry written without ref");
    skip_block_a: assert property (take && (acc.block_hit
        || acc.direct_store) |=> acc_done && !mem_req)
        else $error("block or direct-store access searched");
    skip_real_a: assert property (take && !xlate_on |=>
        acc_done && !mem_req) else $error("untranslated access searched");
    hit_quiet_a: assert property (take && acc.tlb_hit && quiet |=>
        acc_done && !mem_req) else $error("quiet hit searched");
    hit_dirty_a: assert property (paged && acc.tlb_hit && !quiet |=>
        mem_req && !mem_we) else $error("store hit with clean copy idle");
    miss_search_a: assert property (paged && !acc.tlb_hit |=>
        mem_req && !mem_we) else $error("miss did not start search");
    reload_after_a: assert property (mem_req && mem_we && mem_ack |->
        ##[1:3] tlb_load) else $error("no reload after entry write");
    tlb_ref_a: assert property (tlb_load |-> tlb_load_data.r
        && acc_done) else $error("reload without referenced bit");

    // Main scenarios reached
    dirty_hit_c: cover property (paged && acc.tlb_hit && !quiet);
    entry_write_c: cover property (mem_req && mem_we && mem_ack);
    block_skip_c: cover property (take && acc.block_hit);
endmodule : phbu_top_asserts

bind phbu_top phbu_top_asserts u_chk (.*);

// ### bench/phbu_mem_model.sv
`timescale 1ns/1ps
module phbu_mem_model (
    // Clock, reset and answer pacing from the bench
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [3:0]  lat,
    input wire logic        hit_cfg,
    // Memory port of the design
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic            mem_ack,
    output logic [31:0]     mem_rdata,
    output logic            dc_hit
);
    logic [31:0] mem [16];
    logic [3:0]  cnt_r;
    wire  [3:0]  idx = mem_addr[5:2];

    // Scrambled outside an answer, so no stale word can be latched
    assign mem_rdata = mem_ack ? mem[idx] : ~mem[idx];
    assign dc_hit    = mem_req ? hit_cfg : ~hit_cfg;

    // Answer lat + 1 cycles after the request rises; a write lands at its answered edge
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            cnt_r   <= 4'h0;
            mem_ack <= 1'b0;
        end
        else
        begin
            if (mem_req && mem_ack && mem_we)
                mem[idx] <= mem_wdata;
            mem_ack <= mem_req && !mem_ack && cnt_r == lat;
            cnt_r   <= (mem_req && !mem_ack && cnt_r != lat)
                       ? cnt_r + 4'h1 : 4'h0;
        end
    end
endmodule : phbu_mem_model

// ### bench/phbu_tb_top.sv
`timescale 1ns/1ps
`include "phbu_consts.svh"
module phbu_tb_top;
    // Row: flags, enables (instr, data), entry word before and after
    typedef struct packed {
        logic [7:0]  fl;
        logic [1:0]  en;
        logic [31:0] init;
        logic [31:0] expw;
    } phbu_row_t;

    // Flags: instr store touch block dstore hit c ok
    localparam phbu_row_t rows [14] = '{
        '{8'h01, 2'h3, 32'h1234_5000, 32'h1234_5100},
        '{8'h41, 2'h3, 32'h1234_5000, 32'h1234_5180},
        '{8'h61, 2'h3, 32'h1234_5000, 32'h1234_5100},
        '{8'h51, 2'h3, 32'h1234_5000, 32'h1234_5000},
        '{8'h49, 2'h3, 32'h1234_5000, 32'h1234_5000},
        '{8'h41, 2'h2, 32'h1234_5000, 32'h1234_5000},
        '{8'h45, 2'h3, 32'h1234_5100, 32'h1234_5180},
        '{8'h05, 2'h3, 32'h1234_5100, 32'h1234_5100},
        '{8'h47, 2'h3, 32'h1234_5180, 32'h1234_5180},
        '{8'h44, 2'h3, 32'h1234_5100, 32'h1234_5100},
        '{8'h81, 2'h2, 32'h1234_5000, 32'h1234_5100},
        '{8'h81, 2'h1, 32'h1234_5000, 32'h1234_5000},
        '{8'h41, 2'h3, 32'h1234_5180, 32'h1234_5180},
        '{8'h41, 2'h3, 32'hffff_fe7f, 32'hffff_ffff}
    };

    logic                     clk = 1'b0;
    logic                     reset_n = 1'b0;
    logic                     acc_valid = 1'b0;
    phbu_pkg::phbu_acc_t      acc = '0;
    logic                     instr_translate_enable = 1'b1;
    logic                     data_translate_enable = 1'b1;
    logic [7:0]               avs_address = 8'h00;
    logic                     avs_read = 1'b0;
    logic                     avs_write = 1'b0;
    logic [31:0]              avs_writedata = 32'h0;
    wire  [3:0]               avs_byteenable = 4'hf;
    logic [3:0]               lat = 4'h0;
    logic                     hit_cfg = 1'b0;
    logic [3:0]               ops_seen = 4'h0;
    logic                     ops_clr = 1'b0;
    logic [31:0]              q;
    phbu_pkg::phbu_tlb_load_t tl;
    wire logic acc_ready, acc_done, mem_req, mem_we, mem_ack, dc_hit;
    wire logic tlb_load, avs_waitrequest;
    wire logic [31:0]          mem_addr, mem_wdata, mem_rdata, avs_readdata;
    phbu_pkg::phbu_attr_t     mem_attr;
    phbu_pkg::phbu_ext_op_t   mem_ext_op;
    phbu_pkg::phbu_tlb_load_t tlb_load_data;
    int                       error_cnt = 0;
    int                       n_checks = 0;

    phbu_top DUT (.*);
    phbu_mem_model MEM (.*);

    initial
    begin
        forever #25 clk = ~clk;
    end

    // Record transfer kinds and the last entry reload
    always @(posedge clk)
    begin
        if (ops_clr)
            ops_seen <= 4'h0;
        else
            ops_seen[mem_ext_op] <= 1'b1;
        if (tlb_load)
            tl <= tlb_load_data;
    end

    task automatic report_and_stop;
        if (error_cnt == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Bounded wait, 0 ready, 1 done, 2 slave answer; level seen pre-edge
    task automatic wait_on(input int w);
        logic s;
        for (int n = 0; n < 300; n++)
        begin
            @(negedge clk);
            s = (w == 0) ? acc_ready : (w == 1) ? acc_done : !avs_waitrequest;
            @(posedge clk);
            if (s === 1'b1)
                return;
        end
        error_cnt++;
        report_and_stop();
    endtask : wait_on

    // One register access, held until waitrequest is seen low
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !we;
        avs_write     <= we;
        wait_on(2);
        r = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // Offer one access and wait until it is fully handled
    task automatic run(input logic [7:0] f, input logic [1:0] e,
                       input logic [31:0] a);
        @(posedge clk);
        acc_valid              <= 1'b1;
        acc                    <= phbu_pkg::phbu_acc_t'({f, a});
        instr_translate_enable <= e[1];
        data_translate_enable  <= e[0];
        wait_on(0);
        acc_valid <= 1'b0;
        wait_on(1);
        @(negedge clk); // Captures of the last edge settle first
    endtask : run

    initial
    begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        bus(1'b0, `PHBU_OFS_CTRL, 32'h0, q);
        chk(q, `PHBU_CTRL_RST);
        bus(1'b0, 8'h20, 32'h0, q);
        chk(q, 32'h0);
        foreach (rows[i])
        begin
            MEM.mem[i] = rows[i].init;
            lat <= 4'(i % 4);
            run(rows[i].fl, rows[i].en, 32'(i * 4));
            chk(MEM.mem[i], rows[i].expw);
        end
        chk(32'(ops_seen[3:1]), 32'h6);
        // Entry word held in the data cache: nothing goes outside
        ops_clr <= 1'b1;
        @(posedge clk);
        ops_clr <= 1'b0;
        hit_cfg <= 1'b1;
        MEM.mem[15] = 32'h0;
        run(8'h41, 2'h3, 32'h3c);
        chk(32'(ops_seen[3:1]), 32'h0);
        chk(MEM.mem[15], 32'h0000_0180);
        // Cache enabled and missed: a line fill, no single transfers
        bus(1'b1, `PHBU_OFS_CTRL, 32'h3, q);
        bus(1'b0, `PHBU_OFS_CTRL, 32'h0, q);
        chk(q, 32'h3);
        ops_clr <= 1'b1;
        @(posedge clk);
        ops_clr <= 1'b0;
        hit_cfg <= 1'b0;
        MEM.mem[14] = 32'h0;
        run(8'h41, 2'h3, 32'h38);
        chk(32'(ops_seen[3:1]), 32'h1);
        chk(32'(tl[1:0]), 32'h3);
        chk(tl.pte_addr, 32'h38);
        // Activity registers: nine searches, eight entry writes
        bus(1'b0, `PHBU_OFS_SEARCHES, 32'h0, q);
        chk(q, 32'h9);
        bus(1'b0, `PHBU_OFS_WRITES, 32'h0, q);
        chk(q, 32'h8);
        bus(1'b0, `PHBU_OFS_LAST_PTE, 32'h0, q);
        chk(q, 32'h0000_0180);
        bus(1'b0, `PHBU_OFS_STATUS, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b1, `PHBU_OFS_SEARCHES, 32'h0, q);
        bus(1'b0, `PHBU_OFS_SEARCHES, 32'h0, q);
        chk(q, 32'h0);
        // Mid-run reset: idle again, controls back at reset value
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chk({30'h0, acc_ready, acc_done}, 32'h2);
        bus(1'b0, `PHBU_OFS_CTRL, 32'h0, q);
        chk(q, `PHBU_CTRL_RST);
        report_and_stop();
    end
endmodule : phbu_tb_top
